// >>> logic/tofc_core.v
/*
  Time-of-flight measurement core for one converter channel: fine
  interval counter with wrap counter, reference-clock cycle counter,
  overflow abort, early-stop window, two-point calibration, APB slave.
  Assumes START, STOP and REF_CLK are synchronous to CORE_CLK and that
  the fine count advances one tap per core cycle.
*/
// Operation
// - Count oscillator wraps; form fine results for up to six events.
// - Cycle counter counts reference cycles in mode two; five results.
// - Flag wrap overflow when fine result over 63 reaches threshold.
// - Flag cycle overflow when cycle result exceeds its threshold.
// - Any overflow aborts the running measurement at once.
// - Cycle counter starts at first reference edge after start.
// - Mode two: ignore stop pulses before cycle counter reaches the window value.
// - Reset input clears all logic; host gives one clean edge.
// - Calibrate one period, then programmed periods; store both counts.
// - Calibrate after every completed measurement, before completion interrupt.
// - Skip calibration when a measurement is aborted.
// - Mode one times start to each stop with fine counter only.
// - Mode two: fine to edge, cycles to stop, fine to edge.
// - Capture one to five stops as the stop-count field selects.
// - Wait for start without any timeout once armed.
// - Release interrupt pin on new arm or write-one to every set flag.
// - Drop launch output as soon as the start event arrives.
`timescale 1ns/100ps
`default_nettype none
`include "tofc_defines.vh"

module tofc_core #(
  parameter FINE_W = 24,
  parameter CNT_W  = 16
) (
  input  wire        CORE_CLK,         // Core clock, 50 MHz
  input  wire        RST,              // Asynchronous reset, high
  input  wire        PSEL,             // APB select
  input  wire        PENABLE,          // APB access phase
  input  wire        PWRITE,           // APB direction
  input  wire [7:0]  PADDR,            // APB byte address
  input  wire [31:0] PWDATA,           // APB write data
  output reg  [31:0] PRDATA,           // APB read data
  output reg         PREADY,           // APB ready
  output reg         PSLVERR,          // APB error, unmapped address
  input  wire        START,            // Start pulse from front end
  input  wire        STOP,             // Stop pulse from front end
  input  wire        REF_CLK,          // Reference clock, sampled
  output reg         LAUNCH_PULSE_OUT, // Trigger toward front end
  output reg         IRQ_N_PIN         // Interrupt, active low
);

  localparam [8:0] S_IDLE   = 9'h001;
  localparam [8:0] S_WSTART = 9'h002;
  localparam [8:0] S_FINE1  = 9'h004;
  localparam [8:0] S_FSTART = 9'h008;
  localparam [8:0] S_CCNT   = 9'h010;
  localparam [8:0] S_FSTOP  = 9'h020;
  localparam [8:0] S_CALW   = 9'h040;
  localparam [8:0] S_CAL1   = 9'h080;
  localparam [8:0] S_CAL2   = 9'h100;

  reg [8:0]        state_reg;
  reg              mode_reg;
  reg [2:0]        stops_reg;
  reg [7:0]        calp_reg;
  reg [15:0]       wrap_thr_reg;
  reg [15:0]       cycle_thr_reg;
  reg [15:0]       window_reg;
  reg [FINE_W-1:0] cal1_reg;
  reg [FINE_W-1:0] cal2_reg;
  reg [FINE_W-1:0] fine_res_reg [0:`TOFC_FINE_SLOTS-1];
  reg [CNT_W-1:0]  cyc_res_reg  [0:`TOFC_CYCLE_SLOTS-1];
  reg [FINE_W-1:0] fine_reg;
  reg [5:0]        tap_reg;
  reg [15:0]       wrap_reg;
  reg [CNT_W-1:0]  cyc_reg;
  reg [7:0]        per_reg;
  reg [2:0]        idx_reg;
  reg              ready_reg;
  reg              wrap_ovf_reg;
  reg              cyc_ovf_reg;
  reg              start_d_reg;
  reg              stop_d_reg;
  reg              ref_d_reg;

  reg              ready_next;
  reg              wrap_ovf_next;
  reg              cyc_ovf_next;
  reg [31:0]       rdata_next;
  reg              hit_next;
  integer          i;
  integer          j;

  // Word select: true when the address names this offset
  function sel;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      sel = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  // Stop count clamped to the legal range of one to five
  function [2:0] stop_limit;
    input [2:0] f;
    begin
      if (f == 3'h0)
        stop_limit = 3'h1;
      else if (f > `TOFC_MAX_STOPS)
        stop_limit = `TOFC_MAX_STOPS;
      else
        stop_limit = f;
    end
  endfunction

  wire start_rise = START & ~start_d_reg;
  wire stop_rise  = STOP & ~stop_d_reg;
  wire ref_rise   = REF_CLK & ~ref_d_reg;

  wire apb_read  = PSEL & PENABLE & ~PREADY;
  wire apb_fire  = PSEL & PENABLE & PREADY;
  wire wr_fire   = apb_fire & PWRITE;
  wire wr_cfg1   = wr_fire & sel(PADDR, `TOFC_OFS_CONFIG1);
  wire wr_flags  = wr_fire & sel(PADDR, `TOFC_OFS_IRQ_FLAGS);
  wire arm       = wr_cfg1 & PWDATA[`TOFC_CFG1_ARM_BIT];
  wire [2:0] nstop = stop_limit(stops_reg);

  wire fine_run  = (state_reg == S_FINE1) | (state_reg == S_FSTART) |
                   (state_reg == S_FSTOP);
  wire cyc_run   = (state_reg == S_CCNT) | (state_reg == S_FSTOP);
  wire wrap_trip = fine_run & (wrap_reg >= wrap_thr_reg);
  wire cyc_trip  = cyc_run & (cyc_reg > cycle_thr_reg);
  wire abort     = wrap_trip | cyc_trip;
  wire cal_done  = (state_reg == S_CAL2) & ref_rise &
                   (per_reg + 8'h01 >= calp_reg);
  wire stop_ok   = stop_rise & (cyc_reg >= window_reg);
  wire busy      = (state_reg != S_IDLE);

  // Hardware sets win over software write-one clears
  always @* begin
    ready_next    = ready_reg;
    wrap_ovf_next = wrap_ovf_reg;
    cyc_ovf_next  = cyc_ovf_reg;
    if (wr_flags) begin
      if (PWDATA[`TOFC_FLAG_READY_BIT])
        ready_next = 1'b0;
      if (PWDATA[`TOFC_FLAG_WRAP_BIT])
        wrap_ovf_next = 1'b0;
      if (PWDATA[`TOFC_FLAG_CYCLE_BIT])
        cyc_ovf_next = 1'b0;
    end
    if (arm) begin
      ready_next    = 1'b0;
      wrap_ovf_next = 1'b0;
      cyc_ovf_next  = 1'b0;
    end
    if (cal_done)
      ready_next = 1'b1;
    if (wrap_trip)
      wrap_ovf_next = 1'b1;
    if (cyc_trip)
      cyc_ovf_next = 1'b1;
  end

  // Read decode
  always @* begin
    rdata_next = 32'h0000_0000;
    hit_next   = 1'b1;
    if (sel(PADDR, `TOFC_OFS_CONFIG1))
      rdata_next[`TOFC_CFG1_MODE_BIT] = mode_reg;
    else if (sel(PADDR, `TOFC_OFS_CONFIG2)) begin
      rdata_next[`TOFC_CFG2_STOPS_MSB:`TOFC_CFG2_STOPS_LSB] = stops_reg;
      rdata_next[`TOFC_CFG2_CALP_MSB:`TOFC_CFG2_CALP_LSB] = calp_reg;
    end else if (sel(PADDR, `TOFC_OFS_IRQ_FLAGS)) begin
      rdata_next[`TOFC_FLAG_READY_BIT] = ready_reg;
      rdata_next[`TOFC_FLAG_WRAP_BIT]  = wrap_ovf_reg;
      rdata_next[`TOFC_FLAG_CYCLE_BIT] = cyc_ovf_reg;
      rdata_next[`TOFC_FLAG_BUSY_BIT]  = busy;
    end else if (sel(PADDR, `TOFC_OFS_WRAP_THR))
      rdata_next[15:0] = wrap_thr_reg;
    else if (sel(PADDR, `TOFC_OFS_CYCLE_THR))
      rdata_next[15:0] = cycle_thr_reg;
    else if (sel(PADDR, `TOFC_OFS_STOP_WINDOW))
      rdata_next[15:0] = window_reg;
    else if (sel(PADDR, `TOFC_OFS_CAL_SINGLE))
      rdata_next[FINE_W-1:0] = cal1_reg;
    else if (sel(PADDR, `TOFC_OFS_CAL_MULTI))
      rdata_next[FINE_W-1:0] = cal2_reg;
    else
      hit_next = 1'b0;
    for (i = 0; i < `TOFC_FINE_SLOTS; i = i + 1) begin
      if (PADDR[7:2] == `TOFC_OFS_FINE_BASE / 4 + i) begin
        rdata_next = 32'h0000_0000;
        rdata_next[FINE_W-1:0] = fine_res_reg[i];
        hit_next = 1'b1;
      end
    end
    for (i = 0; i < `TOFC_CYCLE_SLOTS; i = i + 1) begin
      if (PADDR[7:2] == `TOFC_OFS_CYCLE_BASE / 4 + i) begin
        rdata_next = 32'h0000_0000;
        rdata_next[CNT_W-1:0] = cyc_res_reg[i];
        hit_next = 1'b1;
      end
    end
  end

  // APB slave: one wait state, registers written at completion edge
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PREADY        <= 1'b0;
      PRDATA        <= 32'h0000_0000;
      PSLVERR       <= 1'b0;
      mode_reg      <= 1'b0;
      stops_reg     <= `TOFC_RST_STOPS;
      calp_reg      <= `TOFC_RST_CALP;
      wrap_thr_reg  <= `TOFC_RST_THR;
      cycle_thr_reg <= `TOFC_RST_THR;
      window_reg    <= `TOFC_RST_WINDOW;
    end else begin
      PREADY  <= apb_read;
      PSLVERR <= apb_read & ~hit_next;
      if (apb_read)
        PRDATA <= PWRITE ? 32'h0000_0000 : rdata_next;
      if (wr_cfg1)
        mode_reg <= PWDATA[`TOFC_CFG1_MODE_BIT];
      if (wr_fire & sel(PADDR, `TOFC_OFS_CONFIG2)) begin
        stops_reg <= PWDATA[`TOFC_CFG2_STOPS_MSB:`TOFC_CFG2_STOPS_LSB];
        calp_reg  <= PWDATA[`TOFC_CFG2_CALP_MSB:`TOFC_CFG2_CALP_LSB];
      end
      if (wr_fire & sel(PADDR, `TOFC_OFS_WRAP_THR))
        wrap_thr_reg <= PWDATA[15:0];
      if (wr_fire & sel(PADDR, `TOFC_OFS_CYCLE_THR))
        cycle_thr_reg <= PWDATA[15:0];
      if (wr_fire & sel(PADDR, `TOFC_OFS_STOP_WINDOW))
        window_reg <= PWDATA[15:0];
    end
  end

  // Measurement sequencer
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_reg        <= S_IDLE;
      fine_reg         <= {FINE_W{1'b0}};
      tap_reg          <= 6'h00;
      wrap_reg         <= 16'h0000;
      cyc_reg          <= {CNT_W{1'b0}};
      per_reg          <= 8'h00;
      idx_reg          <= 3'h0;
      cal1_reg         <= {FINE_W{1'b0}};
      cal2_reg         <= {FINE_W{1'b0}};
      ready_reg        <= 1'b0;
      wrap_ovf_reg     <= 1'b0;
      cyc_ovf_reg      <= 1'b0;
      start_d_reg      <= 1'b0;
      stop_d_reg       <= 1'b0;
      ref_d_reg        <= 1'b0;
      LAUNCH_PULSE_OUT <= 1'b0;
      IRQ_N_PIN        <= 1'b1;
      for (j = 0; j < `TOFC_FINE_SLOTS; j = j + 1)
        fine_res_reg[j] <= {FINE_W{1'b0}};
      for (j = 0; j < `TOFC_CYCLE_SLOTS; j = j + 1)
        cyc_res_reg[j] <= {CNT_W{1'b0}};
    end else begin
      start_d_reg  <= START;
      stop_d_reg   <= STOP;
      ref_d_reg    <= REF_CLK;
      ready_reg    <= ready_next;
      wrap_ovf_reg <= wrap_ovf_next;
      cyc_ovf_reg  <= cyc_ovf_next;
      IRQ_N_PIN    <= ~(ready_next | wrap_ovf_next | cyc_ovf_next);

      // Fine counter with wrap counter, one tap per core cycle
      fine_reg <= fine_reg + 1'b1;
      if (tap_reg == `TOFC_WRAP_DIV - 6'h01) begin
        tap_reg  <= 6'h00;
        wrap_reg <= wrap_reg + 16'h0001;
      end else
        tap_reg <= tap_reg + 6'h01;
      if (cyc_run & ref_rise)
        cyc_reg <= cyc_reg + 1'b1;

      if (arm) begin
        state_reg        <= S_WSTART;
        LAUNCH_PULSE_OUT <= 1'b1;
        idx_reg          <= 3'h0;
      end else if (abort) begin
        state_reg <= S_IDLE;
      end else begin
        case (state_reg)
          S_WSTART: begin
            if (start_rise) begin
              LAUNCH_PULSE_OUT <= 1'b0;
              fine_reg  <= {FINE_W{1'b0}};
              tap_reg   <= 6'h00;
              wrap_reg  <= 16'h0000;
              state_reg <= mode_reg ? S_FSTART : S_FINE1;
            end
          end
          S_FINE1: begin
            if (stop_rise) begin
              fine_res_reg[idx_reg] <= fine_reg;
              idx_reg <= idx_reg + 3'h1;
              if (idx_reg + 3'h1 >= nstop)
                state_reg <= S_CALW;
            end
          end
          S_FSTART: begin
            if (ref_rise) begin
              fine_res_reg[0] <= fine_reg;
              cyc_reg   <= {CNT_W{1'b0}};
              state_reg <= S_CCNT;
            end
          end
          S_CCNT: begin
            if (stop_ok) begin
              cyc_res_reg[idx_reg] <= cyc_reg;
              fine_reg  <= {FINE_W{1'b0}};
              tap_reg   <= 6'h00;
              wrap_reg  <= 16'h0000;
              state_reg <= S_FSTOP;
            end
          end
          S_FSTOP: begin
            if (ref_rise) begin
              fine_res_reg[idx_reg + 3'h1] <= fine_reg;
              idx_reg <= idx_reg + 3'h1;
              if (idx_reg + 3'h1 >= nstop)
                state_reg <= S_CALW;
              else
                state_reg <= S_CCNT;
            end
          end
          S_CALW: begin
            if (ref_rise) begin
              fine_reg  <= {FINE_W{1'b0}};
              state_reg <= S_CAL1;
            end
          end
          S_CAL1: begin
            if (ref_rise) begin
              cal1_reg  <= fine_reg;
              fine_reg  <= {FINE_W{1'b0}};
              per_reg   <= 8'h00;
              state_reg <= S_CAL2;
            end
          end
          S_CAL2: begin
            if (ref_rise) begin
              per_reg <= per_reg + 8'h01;
              if (cal_done) begin
                cal2_reg  <= fine_reg;
                state_reg <= S_IDLE;
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// >>> logic/tofc_defines.vh
/*
  Register map, field positions, reset values and codes of the
  time-of-flight measurement core. Included by the core only.
*/
`ifndef TOFC_DEFINES_VH
`define TOFC_DEFINES_VH

// Word-aligned byte offsets on the APB side
`define TOFC_OFS_CONFIG1      8'h00
`define TOFC_OFS_CONFIG2      8'h04
`define TOFC_OFS_IRQ_FLAGS    8'h08
`define TOFC_OFS_WRAP_THR     8'h0C
`define TOFC_OFS_CYCLE_THR    8'h10
`define TOFC_OFS_STOP_WINDOW  8'h14
`define TOFC_OFS_CAL_SINGLE   8'h18
`define TOFC_OFS_CAL_MULTI    8'h1C
`define TOFC_OFS_FINE_BASE    8'h20
`define TOFC_OFS_CYCLE_BASE   8'h38

// Configuration 1 fields
`define TOFC_CFG1_ARM_BIT     0
`define TOFC_CFG1_MODE_BIT    1

// Second configuration register fields
`define TOFC_CFG2_STOPS_LSB   0
`define TOFC_CFG2_STOPS_MSB   2
`define TOFC_CFG2_CALP_LSB    8
`define TOFC_CFG2_CALP_MSB    15

// Flag register bits
`define TOFC_FLAG_READY_BIT   0
`define TOFC_FLAG_WRAP_BIT    1
`define TOFC_FLAG_CYCLE_BIT   2
`define TOFC_FLAG_BUSY_BIT    3

// Reset values
`define TOFC_RST_STOPS        3'h1
`define TOFC_RST_CALP         8'h0A
`define TOFC_RST_THR          16'hFFFF
`define TOFC_RST_WINDOW       16'h0000

// Ring oscillator taps per wrap, stop limit and result slot counts
`define TOFC_WRAP_DIV         6'h3F
`define TOFC_MAX_STOPS        3'h5
`define TOFC_FINE_SLOTS       6
`define TOFC_CYCLE_SLOTS      5

`endif

// >>> sim/tofc_sva.sv
/*
  Port checker for tofc_core: reset state, launch, interrupt, APB.
  Assumes the bind below attaches it to every core instance.
*/
`timescale 1ns/100ps
`default_nettype none
module tofc_sva (
  input wire logic        CORE_CLK,         // Core clock
  input wire logic        RST,              // Reset, high
  input wire logic        PSEL,             // APB select
  input wire logic        PENABLE,          // APB access
  input wire logic        PWRITE,           // APB direction
  input wire logic [7:0]  PADDR,            // APB address
  input wire logic [31:0] PWDATA,           // APB write data
  input wire logic        PREADY,           // APB ready
  input wire logic        PSLVERR,          // APB error
  input wire logic        START,            // Start pulse
  input wire logic        LAUNCH_PULSE_OUT, // Trigger out
  input wire logic        IRQ_N_PIN         // Interrupt, low
);
  wire logic wr_done = PSEL && PENABLE && PREADY && PWRITE;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  chk_reset_quiet: assert property (disable iff (1'b0)
    RST |-> IRQ_N_PIN && !LAUNCH_PULSE_OUT && !PREADY && !PSLVERR)
    else $error("outputs active during reset");
  chk_launch_holds: assert property (
    LAUNCH_PULSE_OUT && !START && !$past(START) |=> LAUNCH_PULSE_OUT)
    else $error("launch dropped without start");
  chk_launch_drops: assert property (
    LAUNCH_PULSE_OUT && START && !$past(START)
    |-> ##[1:2] !LAUNCH_PULSE_OUT)
    else $error("launch held after start");
  chk_arm_launch: assert property (
    wr_done && PADDR == 8'h00 && PWDATA[0] |-> ##[1:2] LAUNCH_PULSE_OUT)
    else $error("arm write did not launch");
  chk_irq_release: assert property (
    wr_done && PADDR == 8'h08 && PWDATA[2:0] == 3'h7 |-> ##[1:2] IRQ_N_PIN)
    else $error("flag clear left interrupt low");
  chk_arm_release: assert property (
    wr_done && PADDR == 8'h00 && PWDATA[0] |-> ##[1:2] IRQ_N_PIN)
    else $error("arm left interrupt low");
  chk_irq_idle: assert property (
    $fell(IRQ_N_PIN) |-> !LAUNCH_PULSE_OUT)
    else $error("interrupt while waiting for start");
  chk_ready_one: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  chk_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
endmodule

bind tofc_core tofc_sva chk_u (.CORE_CLK(CORE_CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .START(START),
  .LAUNCH_PULSE_OUT(LAUNCH_PULSE_OUT), .IRQ_N_PIN(IRQ_N_PIN));
`default_nettype wire

// >>> sim/tofc_front_end.sv
/*
  Front end and reference clock model: answers a launch with one start
  pulse, then a set number of stop pulses. Runs on the core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tofc_front_end (
  input  wire logic       core_clk,  // Core clock
  input  wire logic       rst,       // Reset, high
  input  wire logic       launch,    // Trigger from core
  input  wire logic [7:0] start_dly, // Cycles launch to start
  input  wire logic [7:0] stop_gap,  // Cycles between pulses
  input  wire logic [2:0] n_stops,   // Stop pulses, 0 for none
  output var  logic       start,     // Start pulse
  output var  logic       stop,      // Stop pulse
  output wire logic       ref_clk    // Reference, 8 core cycles
);
  logic [2:0] ref_reg;
  logic [7:0] cnt_reg;
  logic [2:0] left_reg;
  logic [1:0] ph_reg;
  assign ref_clk = ref_reg[2];
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_reg <= 3'h0;
      cnt_reg <= 8'h00;
      left_reg <= 3'h0;
      ph_reg <= 2'h0;
      start <= 1'b0;
      stop <= 1'b0;
    end else begin
      ref_reg <= ref_reg + 3'h1;
      start <= 1'b0;
      stop <= 1'b0;
      if (cnt_reg != 8'h00)
        cnt_reg <= cnt_reg - 8'h01;
      else if (ph_reg == 2'h0 && launch) begin
        ph_reg <= 2'h1;
        cnt_reg <= start_dly;
      end else if (ph_reg == 2'h1) begin
        start <= 1'b1;
        ph_reg <= 2'h2;
        cnt_reg <= stop_gap;
        left_reg <= n_stops;
      end else if (ph_reg == 2'h2 && left_reg != 3'h0) begin
        stop <= 1'b1;
        left_reg <= left_reg - 3'h1;
        cnt_reg <= stop_gap;
      end else if (ph_reg == 2'h2 && !launch)
        ph_reg <= 2'h0;
    end
  end
endmodule
`default_nettype wire

// >>> sim/tofc_core_bench.sv
/*
  Bench for tofc_core: APB master tasks, front-end model, scenarios.
  Assumes the core answers every APB transfer within a few cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tofc_core_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, q, cs;
  logic        prdy, perr, e, st, sp, rclk, lau, irq_n;
  logic [7:0]  dly = 8'h02, gap = 8'h14;
  logic [2:0]  nst = 3'h1;
  int          n_fail = 0, checks_done = 0, t = 0;

  always #10 clk = ~clk;

  tofc_core dut_u (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .START(st), .STOP(sp), .REF_CLK(rclk),
    .LAUNCH_PULSE_OUT(lau), .IRQ_N_PIN(irq_n));
  tofc_front_end fe_u (.core_clk(clk), .rst(rst), .launch(lau),
    .start_dly(dly), .stop_gap(gap), .n_stops(nst), .start(st),
    .stop(sp), .ref_clk(rclk));

  task automatic wrap_up;
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      n_fail++;
      $display("unexpected at %0t: got %h, want %h", $time, s, x);
    end
  endtask

  task automatic rng(input logic [31:0] v, input logic [31:0] lo,
                     input logic [31:0] hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (prdy !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_irq(input int lim);
    t = 0;
    while (irq_n !== 1'b0) begin
      @(posedge clk);
      t++;
      if (t > lim) begin
        n_fail++;
        wrap_up();
      end
    end
  endtask

  task automatic t_reset;
    rd(8'h04);
    chk(q, 32'h0000_0A01);
    rd(8'h10);
    chk(q, 32'h0000_FFFF);
    rd(8'h14);
    chk(q, 32'h0);
    rd(8'h08);
    chk(q, 32'h0);
    rd(8'h4C);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
  endtask

  task automatic t_mode1;
    dly <= 8'h1E;
    wr(8'h00, 32'h1);
    rd(8'h08);
    chk(q, 32'h8);
    wait_irq(400);
    rng(t, 135, 170);
    rd(8'h20);
    rng(q, 18, 23);
    rd(8'h18);
    rng(q, 6, 10);
    cs = q;
    rd(8'h1C);
    rng(q, 78, 82);
    chk((q - cs) / 32'h9, 32'h8);
    rd(8'h08);
    chk(q, 32'h1);
    wr(8'h08, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_n}, 32'h1);
  endtask

  task automatic t_mode2;
    wr(8'h04, 32'h0A02);
    wr(8'h14, 32'h8);
    wr(8'h10, 32'h40);
    dly <= 8'h02;
    gap <= 8'h28;
    nst <= 3'h3;
    wr(8'h00, 32'h3);
    wait_irq(600);
    rd(8'h38);
    rng(q, 8, 11);
    cs = q;
    rd(8'h3C);
    rng(q - cs, 4, 6);
    rd(8'h20);
    rng(q, 0, 8);
    rd(8'h24);
    rng(q, 0, 8);
    rd(8'h08);
    chk(q, 32'h1);
  endtask

  task automatic t_wrap;
    rd(8'h18);
    cs = q;
    wr(8'h0C, 32'h1);
    nst <= 3'h0;
    wr(8'h00, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_n}, 32'h1);
    wait_irq(200);
    rng(t, 55, 80);
    rd(8'h08);
    chk(q, 32'h2);
    rd(8'h18);
    chk(q, cs);
    wr(8'h08, 32'h7);
    wr(8'h0C, 32'hFFFF);
  endtask

  task automatic t_cycle;
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h2);
    wr(8'h00, 32'h3);
    wait_irq(200);
    rng(t, 20, 50);
    rd(8'h08);
    chk(q, 32'h4);
    wr(8'h08, 32'h7);
  endtask

  task automatic t_midrun_reset;
    wr(8'h00, 32'h3);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk({31'h0, lau}, 32'h0);
    chk({31'h0, irq_n}, 32'h1);
    rd(8'h00);
    chk(q, 32'h0);
    rd(8'h04);
    chk(q, 32'h0000_0A01);
    rd(8'h08);
    chk(q, 32'h0);
  endtask

  initial begin
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mode1();
    t_mode2();
    t_wrap();
    t_cycle();
    t_midrun_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
